// file: sasp_port.sv
// Purpose: Stereo audio serial port, clock master or clock slave.
// Assumes: All pin inputs are synchronous to sys_clk_i.
// Notes:   Bit clock edges become one-cycle rise and fall events inside.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Master drives clock and select; slave receives.
// - Each channel word is 16 bits, MSB first.
// - Left sample MSB leads the serial frame.
// - MSB launched one falling edge after select change.
// - Select low carries left, high carries right.
// - Master frame is 32 or 50 bit clocks.
// - Master bit clock from fractional numerator/denominator divider.
// - Slave works with bit clocks up to 3.072 MHz.
// - Master clock halves each at least 0.35 period.
module sasp_port
  import sasp_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       en_i,
  // Configuration.
  input  wire sasp_cfg_t  cfg_i,
  // Sample streams.
  input  wire sasp_pair_t tx_pair_i,
  output logic            tx_take_o,
  output sasp_pair_t      rx_pair_o,
  output logic            rx_valid_o,
  // Bit clock pin.
  input  wire logic       bclk_i,
  output logic            bclk_o,
  output logic            bclk_oe_n_o,
  // Word select pin.
  input  wire logic       ws_i,
  output logic            ws_o,
  output logic            ws_oe_n_o,
  // Serial data pins.
  input  wire logic       serial_audio_in_i,
  output logic            serial_audio_out_o
);

  logic                  bclk_r,     bclk_nxt;
  logic                  bclk_d_r,   bclk_d_nxt;
  logic [SASP_DIV_W-1:0] acc_r,      acc_nxt;
  logic                  ws_r,       ws_nxt;
  logic                  ws_last_r,  ws_last_nxt;
  logic                  ws_chg_r,   ws_chg_nxt;
  logic [4:0]            slot_cnt_r, slot_cnt_nxt;
  logic [15:0]           tx_sh_r,    tx_sh_nxt;
  logic                  sdo_r,      sdo_nxt;
  logic [15:0]           r_hold_r,   r_hold_nxt;
  logic [15:0]           rx_sh_r,    rx_sh_nxt;
  logic [4:0]            rx_cnt_r,   rx_cnt_nxt;
  logic [15:0]           l_hold_r,   l_hold_nxt;
  sasp_pair_t            rx_pair_r,  rx_pair_nxt;
  logic                  rx_vld_r,   rx_vld_nxt;
  logic                  take_r,     take_nxt;

  logic [SASP_DIV_W:0]   acc_sum;
  logic                  wrap;
  logic                  rise_ev;
  logic                  fall_ev;
  logic                  ws_now;
  logic                  tx_load;
  logic [4:0]            slot_last;
  logic [15:0]           tx_word;
  logic [15:0]           rx_new;

  always_comb begin
    acc_sum   = {1'b0, acc_r} + {1'b0, cfg_i.div_num};
    wrap      = acc_sum >= {1'b0, cfg_i.div_den};
    rise_ev   = cfg_i.master ? (wrap & ~bclk_r) : (bclk_i & ~bclk_d_r);
    fall_ev   = cfg_i.master ? (wrap & bclk_r) : (~bclk_i & bclk_d_r);
    ws_now    = cfg_i.master ? ws_r : ws_i;
    slot_last = cfg_i.long_frame ? SASP_SLOT_LAST_LONG : SASP_SLOT_LAST_SHRT;
    tx_load   = fall_ev & ws_chg_r;
    tx_word   = ws_last_r ? r_hold_r : tx_pair_i.left;
    rx_new    = {rx_sh_r[14:0], serial_audio_in_i};

    bclk_nxt     = bclk_r;
    bclk_d_nxt   = bclk_i;
    acc_nxt      = acc_r;
    ws_nxt       = ws_r;
    ws_last_nxt  = ws_last_r;
    ws_chg_nxt   = ws_chg_r;
    slot_cnt_nxt = slot_cnt_r;
    tx_sh_nxt    = tx_sh_r;
    sdo_nxt      = sdo_r;
    r_hold_nxt   = r_hold_r;
    rx_sh_nxt    = rx_sh_r;
    rx_cnt_nxt   = rx_cnt_r;
    l_hold_nxt   = l_hold_r;
    rx_pair_nxt  = rx_pair_r;
    rx_vld_nxt   = 1'b0;
    take_nxt     = 1'b0;

    if (cfg_i.master) begin
      acc_nxt = wrap ? SASP_DIV_W'(acc_sum - {1'b0, cfg_i.div_den}) : acc_sum[SASP_DIV_W-1:0];
      if (wrap) begin
        bclk_nxt = ~bclk_r;
      end
    end else begin
      acc_nxt  = '0;
      bclk_nxt = SASP_BCLK_RST;
    end

    if (rise_ev) begin
      if (rx_cnt_r < SASP_WORD_DONE) begin
        rx_sh_nxt  = rx_new;
        rx_cnt_nxt = rx_cnt_r + 5'h01;
        if (rx_cnt_r == SASP_WORD_LAST) begin
          if (!ws_last_r) begin
            l_hold_nxt = rx_new;
          end else begin
            rx_pair_nxt = '{right: rx_new, left: l_hold_r};
            rx_vld_nxt  = 1'b1;
          end
        end
      end
      if (ws_now != ws_last_r) begin
        rx_cnt_nxt = 5'h00;
      end
      ws_last_nxt = ws_now;
      ws_chg_nxt  = ws_now != ws_last_r;
    end

    if (fall_ev) begin
      if (ws_chg_r) begin
        sdo_nxt    = tx_word[15];
        tx_sh_nxt  = {tx_word[14:0], 1'b0};
        ws_chg_nxt = 1'b0;
        if (!ws_last_r) begin
          r_hold_nxt = tx_pair_i.right;
          take_nxt   = 1'b1;
        end
      end else begin
        sdo_nxt   = tx_sh_r[15];
        tx_sh_nxt = {tx_sh_r[14:0], 1'b0};
      end
      if (cfg_i.master) begin
        if (slot_cnt_r >= slot_last) begin
          slot_cnt_nxt = 5'h00;
          ws_nxt       = ~ws_r;
        end else begin
          slot_cnt_nxt = slot_cnt_r + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bclk_r     <= SASP_BCLK_RST;
      bclk_d_r   <= SASP_BCLK_RST;
      acc_r      <= '0;
      ws_r       <= SASP_WS_RST;
      ws_last_r  <= SASP_WS_RST;
      ws_chg_r   <= 1'b0;
      slot_cnt_r <= 5'h00;
      tx_sh_r    <= 16'h0000;
      sdo_r      <= 1'b0;
      r_hold_r   <= 16'h0000;
      rx_sh_r    <= 16'h0000;
      rx_cnt_r   <= SASP_CNT_RST;
      l_hold_r   <= 16'h0000;
      rx_pair_r  <= '0;
      rx_vld_r   <= 1'b0;
      take_r     <= 1'b0;
    end else if (en_i) begin
      bclk_r     <= bclk_nxt;
      bclk_d_r   <= bclk_d_nxt;
      acc_r      <= acc_nxt;
      ws_r       <= ws_nxt;
      ws_last_r  <= ws_last_nxt;
      ws_chg_r   <= ws_chg_nxt;
      slot_cnt_r <= slot_cnt_nxt;
      tx_sh_r    <= tx_sh_nxt;
      sdo_r      <= sdo_nxt;
      r_hold_r   <= r_hold_nxt;
      rx_sh_r    <= rx_sh_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      l_hold_r   <= l_hold_nxt;
      rx_pair_r  <= rx_pair_nxt;
      rx_vld_r   <= rx_vld_nxt;
      take_r     <= take_nxt;
    end else begin
      rx_vld_r   <= 1'b0;
      take_r     <= 1'b0;
    end
  end

  assign bclk_oe_n_o        = ~cfg_i.master;
  assign ws_oe_n_o          = ~cfg_i.master;
  assign bclk_o             = bclk_r;
  assign ws_o               = ws_r;
  assign serial_audio_out_o = sdo_r;
  assign rx_pair_o          = rx_pair_r;
  assign rx_valid_o         = rx_vld_r;
  assign tx_take_o          = take_r;

  // Helper count of enabled cycles since the last divider toggle.
  logic [15:0] half_cnt_r;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      half_cnt_r <= 16'h0000;
    end else if (en_i) begin
      half_cnt_r <= (wrap && cfg_i.master) ? 16'h0000 :
                    (half_cnt_r == 16'hFFFF ? half_cnt_r : half_cnt_r + 16'h0001);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_pin_dir;
    cfg_i.master ? (!bclk_oe_n_o && !ws_oe_n_o) : (bclk_oe_n_o && ws_oe_n_o);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong for mode");

  property p_word_len;
    en_i && rise_ev && rx_cnt_r == SASP_WORD_LAST |=> rx_cnt_r == SASP_WORD_DONE || rx_cnt_r == 5'h00;
  endproperty
  a_word_len: assert property (p_word_len) else $error("receive word not sixteen bits");

  property p_left_msb;
    en_i && tx_load && !ws_last_r |=> serial_audio_out_o == $past(tx_pair_i.left[15]) && tx_take_o;
  endproperty
  a_left_msb: assert property (p_left_msb) else $error("left MSB not sent first");

  property p_msb_on_fall;
    en_i && $rose(ws_chg_r) |-> !fall_ev;
  endproperty
  a_msb_on_fall: assert property (p_msb_on_fall) else $error("MSB launched without bit delay");

  property p_right_word;
    en_i && tx_load && ws_last_r |=> serial_audio_out_o == $past(r_hold_r[15]) && !tx_take_o;
  endproperty
  a_right_word: assert property (p_right_word) else $error("right word sent on wrong select");

  property p_slot_len;
    cfg_i.master && $changed(ws_o) |-> $past(slot_cnt_r) == $past(slot_last) && slot_cnt_r == 5'h00;
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot length wrong");

  property p_div_toggle;
    cfg_i.master && $changed(bclk_o) |-> $past(wrap) && $past(en_i);
  endproperty
  a_div_toggle: assert property (p_div_toggle) else $error("bit clock toggled off divider");

  property p_slave_edge;
    !cfg_i.master && en_i && bclk_i && !bclk_d_r |-> rise_ev && !fall_ev;
  endproperty
  a_slave_edge: assert property (p_slave_edge) else $error("slave rising edge missed");

  property p_half_len;
    cfg_i.master && en_i && wrap && $stable(cfg_i) && cfg_i.div_num != '0 |->
      (32'(half_cnt_r) + 32'd1) * 32'(cfg_i.div_num) + 32'(cfg_i.div_num) > 32'(cfg_i.div_den);
  endproperty
  a_half_len: assert property (p_half_len) else $error("bit clock phase too short");

  property p_ws_on_fall;
    cfg_i.master && $changed(ws_o) |-> $fell(bclk_o);
  endproperty
  a_ws_on_fall: assert property (p_ws_on_fall) else $error("select changed off falling edge");

  c_master_left: cover property (cfg_i.master && tx_load && !ws_last_r);
  c_slave_rx:    cover property (!cfg_i.master && rx_valid_o);
  c_long_frame:  cover property (cfg_i.master && cfg_i.long_frame && $changed(ws_o));

endmodule : sasp_port
`default_nettype wire

// file: sasp_pkg.sv
// Purpose: Shared constants and carrier types for the stereo audio serial port.
// Assumes: System clock of 40 MHz; 16-bit samples.
// Notes:   Divider pairs give the toggle rate, which is twice the bit clock.
`default_nettype none
package sasp_pkg;
  localparam int SASP_WORD_BITS       = 16;
  localparam int SASP_FRAME_BITS_SHRT = 32;
  localparam int SASP_FRAME_BITS_LONG = 50;
  localparam int SASP_FRAME_RATE_HZ   = 48000;
  localparam int SASP_SYS_CLK_HZ      = 40000000;
  localparam int SASP_SLV_BCLK_MAX_HZ = 3072000;
  localparam int SASP_DUTY_MIN_PCT    = 35;
  localparam int SASP_SLV_HALF_MIN_CYC =
    (SASP_SYS_CLK_HZ * SASP_DUTY_MIN_PCT / 100) / SASP_SLV_BCLK_MAX_HZ;
  localparam int SASP_DIV_W           = 16;
  localparam logic [15:0] SASP_DIV_NUM_1536 = 16'h0030;
  localparam logic [15:0] SASP_DIV_DEN_1536 = 16'h0271;
  localparam logic [15:0] SASP_DIV_NUM_2400 = 16'h0003;
  localparam logic [15:0] SASP_DIV_DEN_2400 = 16'h0019;
  localparam logic [4:0]  SASP_SLOT_LAST_SHRT = 5'(SASP_FRAME_BITS_SHRT / 2 - 1);
  localparam logic [4:0]  SASP_SLOT_LAST_LONG = 5'(SASP_FRAME_BITS_LONG / 2 - 1);
  localparam logic [4:0]  SASP_WORD_LAST    = 5'(SASP_WORD_BITS - 1);
  localparam logic [4:0]  SASP_WORD_DONE    = 5'(SASP_WORD_BITS);
  localparam logic        SASP_BCLK_RST     = 1'b0;
  localparam logic        SASP_WS_RST       = 1'b0;
  localparam logic [4:0]  SASP_CNT_RST      = 5'h10;

  typedef struct packed {
    logic [SASP_WORD_BITS-1:0] right;
    logic [SASP_WORD_BITS-1:0] left;
  } sasp_pair_t;

  typedef struct packed {
    logic                  master;
    logic                  long_frame;
    logic [SASP_DIV_W-1:0] div_num;
    logic [SASP_DIV_W-1:0] div_den;
  } sasp_cfg_t;
endpackage : sasp_pkg
`default_nettype wire

// file: sasp_partner.sv
// Purpose: Audio partner model for the serial port bench.
// Assumes: Pin levels seen here are already resolved.
// Notes:   Makes clock and select only while the port is slave.
`timescale 1ns/1ps
`default_nettype none
module sasp_partner
  import sasp_pkg::*;
#(
  parameter int HALF_CYC  = 7,
  parameter int SLOT_BCLK = 20
) (
  // Clock and mode.
  input  wire logic       sys_clk_i,
  input  wire logic       master_i,
  // Resolved pins.
  input  wire logic       bclk_i,
  input  wire logic       ws_i,
  input  wire logic       serial_audio_out_i,
  // Pair to send and pair seen.
  input  wire sasp_pair_t src_pair_i,
  output logic            bclk_o,
  output logic            ws_o,
  output logic            serial_audio_in_o,
  output sasp_pair_t      got_pair_o,
  output logic            got_valid_o
);
  int          hc    = 0;
  int          fc    = 0;
  int          k     = 99;
  int          j     = 99;
  logic        bprev = 1'b0;
  logic        wlast = 1'b0;
  logic        seen  = 1'b0;
  logic        chg   = 1'b0;
  logic [15:0] word  = 16'h0000;
  logic [15:0] lword = 16'h0000;
  initial begin
    bclk_o = 1'b0;
    ws_o = 1'b0;
    serial_audio_in_o = 1'b0;
    got_valid_o = 1'b0;
    got_pair_o = '0;
  end
  always @(posedge sys_clk_i) begin
    got_valid_o <= 1'b0;
    if (!master_i) begin
      hc = (hc == HALF_CYC - 1) ? 0 : hc + 1;
      if (hc == 0) begin
        bclk_o <= ~bclk_o;
        if (bclk_o) begin
          fc = (fc == SLOT_BCLK - 1) ? 0 : fc + 1;
          if (fc == 0) ws_o <= ~ws_o;
        end
      end
    end
    if (bclk_i && !bprev) begin
      if (k < 16) word[15-k] = serial_audio_out_i;
      k = k + 1;
      if (ws_i !== wlast) begin
        if (seen && wlast) begin
          got_pair_o <= {word, lword};
          got_valid_o <= 1'b1;
        end
        if (seen && !wlast) lword = word;
        seen = 1'b1;
        wlast = ws_i;
        k = 0;
        chg = 1'b1;
      end
    end
    if (!bclk_i && bprev) begin
      j = chg ? 0 : j + 1;
      chg = 1'b0;
      if (j < 16) serial_audio_in_o <= src_pair_i[(wlast ? 31 : 15) - j];
      else serial_audio_in_o <= ~serial_audio_in_o;
    end
    bprev = bclk_i;
  end
endmodule : sasp_partner
`default_nettype wire

// file: stereo_audio_serial_port_test.sv
// Purpose: Self-checking bench for the stereo audio serial port.
// Assumes: 40 MHz clock and a partner model on the far side.
// Notes:   Covers both master rates, slave mode, enable and reset.
`timescale 1ns/1ps
`default_nettype none
module stereo_audio_serial_port_test;
  import sasp_pkg::*;
  logic       sys_clk, resetn, en, tx_take, rx_valid, bclk_o, bclk_oe_n, ws_o, ws_oe_n;
  logic       serial_audio_out, serial_audio_in, p_bclk, p_ws, got_valid, bprev, wprev;
  sasp_cfg_t  cfg;
  sasp_pair_t tx_pair, src, rx_pair, got;
  int         error_cnt = 0, samples_checked = 0, cyc = 0, run = 0, mn = 999, mx = 0;
  int         rises = 0, fcyc = 0, f_rises = 0, f_cyc = 0, f_mn = 0, f_mx = 0;
  wire logic  bclk = bclk_oe_n ? p_bclk : bclk_o;
  wire logic  ws = ws_oe_n ? p_ws : ws_o;
  sasp_port dut (.sys_clk_i(sys_clk), .resetn_i(resetn), .en_i(en), .cfg_i(cfg), .tx_pair_i(tx_pair),
    .tx_take_o(tx_take), .rx_pair_o(rx_pair), .rx_valid_o(rx_valid), .bclk_i(bclk), .bclk_o(bclk_o),
    .bclk_oe_n_o(bclk_oe_n), .ws_i(ws), .ws_o(ws_o), .ws_oe_n_o(ws_oe_n),
    .serial_audio_in_i(serial_audio_in), .serial_audio_out_o(serial_audio_out));
  sasp_partner #(.HALF_CYC(7), .SLOT_BCLK(20)) partner (.sys_clk_i(sys_clk), .master_i(cfg.master),
    .bclk_i(bclk), .ws_i(ws), .serial_audio_out_i(serial_audio_out), .src_pair_i(src), .bclk_o(p_bclk), .ws_o(p_ws),
    .serial_audio_in_o(serial_audio_in), .got_pair_o(got), .got_valid_o(got_valid));
  always #12.5 sys_clk = ~sys_clk;
  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic fail(input string msg);
    error_cnt++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail
  task automatic chk(input logic [31:0] a, input logic [31:0] b, input string msg);
    samples_checked++;
    if (a !== b) fail(msg);
  endtask : chk
  // Frame statistics are latched at every select rise.
  always @(posedge sys_clk) begin
    if (bclk !== bprev) begin
      mn = (run < mn) ? run : mn;
      mx = (run > mx) ? run : mx;
      run = 0;
      rises += bclk;
    end
    run++;
    fcyc++;
    if (ws && !wprev) begin
      f_rises = rises;
      f_cyc = fcyc;
      f_mn = mn;
      f_mx = mx;
      rises = 0;
      fcyc = 0;
      mn = 999;
      mx = 0;
    end
    if (!ws_oe_n && ws_o !== wprev && bclk_o !== 1'b0) fail("select moved while clock high");
    bprev = bclk;
    wprev = ws;
    cyc++;
    if (cyc == 60000) begin
      fail("timeout");
      print_verdict();
    end
  end
  task automatic wait_ev(input int sel, input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge sys_clk);
        k++;
      end while (!(sel ? rx_valid === 1'b1 : got_valid === 1'b1) && k < 5000);
      if (k == 5000) fail("no pair seen");
    end
  endtask : wait_ev
  task automatic t_run(input logic m, input logic lf, input logic [15:0] num, input logic [15:0] den,
                       input int bits, input sasp_pair_t p, input sasp_pair_t q);
    @(posedge sys_clk);
    resetn <= 1'b0;
    cfg <= '{master: m, long_frame: lf, div_num: num, div_den: den};
    tx_pair <= p;
    src <= q;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    chk({bclk_oe_n, ws_oe_n}, {~m, ~m}, "pin direction");
    wait_ev(0, 3);
    chk(got, p, "sent pair");
    if (m) begin
      chk(f_rises, bits, "bit clocks per frame");
      chk(f_cyc inside {833, 834}, 1, "frame rate");
      chk(f_mn * 100 * bits >= 35 * 833, 1, "clock phase too short");
      chk(f_mx - f_mn <= 1, 1, "clock ratio not fixed");
    end
    wait_ev(1, 2);
    chk(rx_pair, q, "received pair");
  endtask : t_run
  task automatic t_hold();
    int   n;
    logic b;
    logic s;
    n = 0;
    @(posedge sys_clk);
    en <= 1'b0;
    @(negedge sys_clk);
    b = bclk_o;
    s = serial_audio_out;
    repeat (100) begin
      @(negedge sys_clk);
      n += (bclk_o !== b) + (tx_take !== 1'b0) + (rx_valid !== 1'b0) + (serial_audio_out !== s);
    end
    chk(n, 0, "activity while disabled");
    @(posedge sys_clk);
    en <= 1'b1;
    wait_ev(0, 1);
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(negedge sys_clk);
    chk({bclk_o, ws_o, serial_audio_out, rx_valid, tx_take}, 0, "reset levels");
    @(posedge sys_clk);
    resetn <= 1'b1;
  endtask : t_hold
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    en = 1'b1;
    cfg = '0;
    tx_pair = '0;
    src = '0;
    bprev = 1'b0;
    wprev = 1'b0;
    t_run(1'b1, 1'b0, SASP_DIV_NUM_1536, SASP_DIV_DEN_1536, 32, 32'hA5C3_0F81, 32'h8001_7FFE);
    t_run(1'b1, 1'b1, SASP_DIV_NUM_2400, SASP_DIV_DEN_2400, 50, 32'h1234_FEDC, 32'hC0DE_4B2D);
    t_hold();
    t_run(1'b0, 1'b0, SASP_DIV_NUM_1536, SASP_DIV_DEN_1536, 32, 32'h7FFF_8000, 32'h0F0F_F0F0);
    print_verdict();
  end
endmodule : stereo_audio_serial_port_test
`default_nettype wire
